/* core/gpio_cfg_regs.svh */
`ifndef GPIO_CFG_REGS_SVH
`define GPIO_CFG_REGS_SVH

// ----------------------------------------------------------------
// Register offsets in the I/O space
// ----------------------------------------------------------------
`define OFS_PORT0_DATA 8'h00
`define OFS_PORT1_DATA 8'h01
`define OFS_PORT0_PIN1_CONFIG 8'h06
`define OFS_EXT_IRQ1_PIN_CONFIG 8'h08
`define OFS_EXT_IRQ2_PIN_CONFIG 8'h09
`define OFS_PORT0_PIN7_CONFIG 8'h0C
`define OFS_PORT1_PIN0_CONFIG 8'h0D
`define OFS_PORT1_PIN1_CONFIG 8'h0E
`define OFS_PORT1_PIN2_CONFIG 8'h0F
`define OFS_SERIAL_PIN_CTRL 8'h1A
`define OFS_CRYSTAL_CTRL 8'h1B

// ----------------------------------------------------------------
// Writable bits per register, reserved bits read as zero
// ----------------------------------------------------------------
`define MASK_PORT0_PIN1 8'hFF
`define MASK_EXT_IRQ_PIN 8'h37
`define MASK_PORT0_PIN7 8'h77
`define MASK_PORT1_PIN0 8'hE3
`define MASK_PORT1_PIN1 8'h65
`define MASK_PORT1_PIN2 8'hF7
`define MASK_SERIAL_PIN 8'hFF
`define MASK_CRYSTAL 8'h03

// ----------------------------------------------------------------
// Common field positions of a pin configuration byte, then crystal and serial control fields
// ----------------------------------------------------------------
`define BIT_OUT_EN 0
`define BIT_PULLUP 1
`define BIT_OPEN_DRAIN 2
`define BIT_HIGH_SINK 3
`define BIT_TTL 4
`define BIT_ACT_LOW 5
`define BIT_IRQ_EN 6
`define BIT_CLK_OUT 7
`define BIT_CRYSTAL_IN_OE 0
`define BIT_CRYSTAL_OSC_ON 1
`define SERIAL_OE_LSB 4

// ----------------------------------------------------------------
// Pin indices: 0..7 port 0, 8..15 port 1
// ----------------------------------------------------------------
`define PIN_CRYSTAL_IN 0
`define PIN_CRYSTAL_OUT 1
`define PIN_EXT_IRQ_A 3
`define PIN_EXT_IRQ_B 4
`define PIN_P07 7
`define PIN_P10 8
`define PIN_P11 9
`define PIN_P12 10
`define PIN_SERIAL_FIRST 11
`define PIN_SERIAL_LAST 14

`define RST_BYTE 8'h00
`define RST_PINS 16'h0000

`endif

/* core/gpio_cfg_pkg.sv */
package gpio_cfg_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] pin_vec_t;
  typedef logic [3:0] serial_vec_t;
endpackage

/* core/gpio_pin_configuration.sv */
`timescale 1ns/1ps
`include "gpio_cfg_regs.svh"

// What this block does
// - Open-drain set: data one floats the pin, data zero drives it low.
// - Open-drain clear: enabled pin is driven high and low from data.
// - Pull-up bit connects the pin's 7K pull-up; clear disconnects it.
// - Output enable bit switches the output driver on or off.
// - Crystal running forces crystal in and out pin drivers off.
// - Serial claim bit hands output control of serial pins to serial logic.
// - Port 0 pin 1 register at 0x06 holds its documented field layout.
// - External interrupt pins fire on rising or falling edge per polarity.
// - External interrupt pins use separate registers at 0x08 and 0x09.
// - Driving an interrupt pin from data triggers it like an edge.
// - Pad settings of interrupt pins apply in both interrupt and GPIO use.
// - Port 0 pin 7 register at 0x0C holds its layout, bits 7 and 3 reserved.
// - Port 1 pin 0 register at 0x0D holds its layout, bits 4..2 reserved.
// - Port 1 pin 0 only pulls low, never drives high.
// - Port 1 pin 0 bit 1 enables 5K pull-ups on pins 1.0 and 1.1.
// - Port 1 pin 1 register at 0x0E holds its layout, rest reserved.
// - Port 1 pin 2 bit 7 routes the selected clock onto that pin.
// - Interrupt enable lets a pin interrupt on the one edge its polarity bit selects.
// - Threshold bit selects TTL when set, CMOS when clear.
// - Data writes set output values; data reads return pin levels.
module gpio_pin_configuration (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [7:0] RD_DATA,
  input wire logic [15:0] PIN_IN,
  output logic [15:0] PIN_OUT,
  output logic [15:0] PIN_OE,
  output logic [15:0] PIN_PULLUP,
  output logic [15:0] PIN_TTL,
  output logic [15:0] PIN_HISINK,
  input wire logic [3:0] SER_OE,
  input wire logic [3:0] SER_DO,
  input wire logic SEL_CLK,
  output logic EXT_IRQ_A,
  output logic EXT_IRQ_B,
  output logic [15:0] GPIO_IRQ
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  gpio_cfg_pkg::byte_t p0_data_reg;
  gpio_cfg_pkg::byte_t p1_data_reg;
  gpio_cfg_pkg::byte_t cfg01_reg;
  gpio_cfg_pkg::byte_t cfg03_reg;
  gpio_cfg_pkg::byte_t cfg04_reg;
  gpio_cfg_pkg::byte_t cfg07_reg;
  gpio_cfg_pkg::byte_t cfg10_reg;
  gpio_cfg_pkg::byte_t cfg11_reg;
  gpio_cfg_pkg::byte_t cfg12_reg;
  gpio_cfg_pkg::byte_t serial_reg;
  gpio_cfg_pkg::byte_t crystal_reg;
  gpio_cfg_pkg::pin_vec_t pin_prev_reg;
  logic primed_reg;
  logic sel_clk_reg;
  gpio_cfg_pkg::byte_t rd_next;
  gpio_cfg_pkg::byte_t pcfg [16];
  gpio_cfg_pkg::pin_vec_t data_all;
  gpio_cfg_pkg::pin_vec_t oe_eff;
  gpio_cfg_pkg::pin_vec_t dat_eff;
  gpio_cfg_pkg::pin_vec_t od_eff;
  gpio_cfg_pkg::pin_vec_t drive_next;
  gpio_cfg_pkg::pin_vec_t out_next;
  gpio_cfg_pkg::pin_vec_t edge_hit;
  gpio_cfg_pkg::serial_vec_t claim;
  logic crystal_osc_on;

  assign claim = serial_reg[3:0];
  assign crystal_osc_on = crystal_reg[`BIT_CRYSTAL_OSC_ON];
  assign data_all = {p1_data_reg, p0_data_reg};

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Reserved bits are masked on the way in so they always read zero
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg01_reg <= `RST_BYTE;
      cfg03_reg <= `RST_BYTE;
      cfg04_reg <= `RST_BYTE;
      cfg07_reg <= `RST_BYTE;
      cfg10_reg <= `RST_BYTE;
      cfg11_reg <= `RST_BYTE;
      cfg12_reg <= `RST_BYTE;
      serial_reg <= `RST_BYTE;
      crystal_reg <= `RST_BYTE;
    end else if (WR_EN) begin
      unique case (ADDR)
        `OFS_PORT0_PIN1_CONFIG: begin
          cfg01_reg <= WR_DATA & `MASK_PORT0_PIN1;
        end
        `OFS_EXT_IRQ1_PIN_CONFIG: begin
          cfg03_reg <= WR_DATA & `MASK_EXT_IRQ_PIN;
        end
        `OFS_EXT_IRQ2_PIN_CONFIG: begin
          cfg04_reg <= WR_DATA & `MASK_EXT_IRQ_PIN;
        end
        `OFS_PORT0_PIN7_CONFIG: begin
          cfg07_reg <= WR_DATA & `MASK_PORT0_PIN7;
        end
        `OFS_PORT1_PIN0_CONFIG: begin
          cfg10_reg <= WR_DATA & `MASK_PORT1_PIN0;
        end
        `OFS_PORT1_PIN1_CONFIG: begin
          cfg11_reg <= WR_DATA & `MASK_PORT1_PIN1;
        end
        `OFS_PORT1_PIN2_CONFIG: begin
          cfg12_reg <= WR_DATA & `MASK_PORT1_PIN2;
        end
        `OFS_SERIAL_PIN_CTRL: begin
          serial_reg <= WR_DATA & `MASK_SERIAL_PIN;
        end
        `OFS_CRYSTAL_CTRL: begin
          crystal_reg <= WR_DATA & `MASK_CRYSTAL;
        end
        default: begin
        end
      endcase
    end
  end

  // Port data latches the byte written to its offset, for every pin
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      p0_data_reg <= `RST_BYTE;
      p1_data_reg <= `RST_BYTE;
    end else if (WR_EN) begin
      if (ADDR == `OFS_PORT0_DATA) begin
        p0_data_reg <= WR_DATA;
      end
      if (ADDR == `OFS_PORT1_DATA) begin
        p1_data_reg <= WR_DATA;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads, answered one cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    rd_next = `RST_BYTE;
    unique case (ADDR)
      `OFS_PORT0_DATA: rd_next = PIN_IN[7:0];
      `OFS_PORT1_DATA: rd_next = PIN_IN[15:8];
      `OFS_PORT0_PIN1_CONFIG: rd_next = cfg01_reg;
      `OFS_EXT_IRQ1_PIN_CONFIG: rd_next = cfg03_reg;
      `OFS_EXT_IRQ2_PIN_CONFIG: rd_next = cfg04_reg;
      `OFS_PORT0_PIN7_CONFIG: rd_next = cfg07_reg;
      `OFS_PORT1_PIN0_CONFIG: rd_next = cfg10_reg;
      `OFS_PORT1_PIN1_CONFIG: rd_next = cfg11_reg;
      `OFS_PORT1_PIN2_CONFIG: rd_next = cfg12_reg;
      `OFS_SERIAL_PIN_CTRL: rd_next = serial_reg;
      `OFS_CRYSTAL_CTRL: rd_next = crystal_reg;
      default: rd_next = `RST_BYTE;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RD_DATA <= `RST_BYTE;
    end else if (RD_EN) begin
      RD_DATA <= rd_next;
    end else begin
      RD_DATA <= `RST_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // Per-pin configuration view
  // ----------------------------------------------------------------
  // Unmodelled pins see an all-zero byte: input, no pull, no interrupt
  always_comb begin
    for (int k = 0; k < 16; k++) begin
      pcfg[k] = `RST_BYTE;
    end
    pcfg[`PIN_CRYSTAL_IN][`BIT_OUT_EN] = crystal_reg[`BIT_CRYSTAL_IN_OE];
    pcfg[`PIN_CRYSTAL_OUT] = cfg01_reg;
    pcfg[`PIN_EXT_IRQ_A] = cfg03_reg;
    pcfg[`PIN_EXT_IRQ_B] = cfg04_reg;
    pcfg[`PIN_P07] = cfg07_reg;
    pcfg[`PIN_P10] = cfg10_reg;
    pcfg[`PIN_P11] = cfg11_reg;
    // Shared 5K pull-up for pins 1.0 and 1.1 lives in one bit
    pcfg[`PIN_P11][`BIT_PULLUP] = cfg10_reg[`BIT_PULLUP];
    pcfg[`PIN_P12] = cfg12_reg;
    for (int k = 0; k < 4; k++) begin
      pcfg[`PIN_SERIAL_FIRST + k][`BIT_TTL] = 1'b1;
      pcfg[`PIN_SERIAL_FIRST + k][`BIT_OUT_EN] =
        serial_reg[`SERIAL_OE_LSB + k];
    end
  end

  // ----------------------------------------------------------------
  // Pad drive and interrupt edges, one slice per pin
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < 16; i++) begin : g_pin
      if (i == `PIN_CRYSTAL_IN || i == `PIN_CRYSTAL_OUT) begin : g_xtal
        // Oscillator owns these pads while it runs
        assign oe_eff[i] = pcfg[i][`BIT_OUT_EN] & ~crystal_osc_on;
      end else if (i >= `PIN_SERIAL_FIRST && i <= `PIN_SERIAL_LAST)
      begin : g_ser
        assign oe_eff[i] = claim[i - `PIN_SERIAL_FIRST] ?
          SER_OE[i - `PIN_SERIAL_FIRST] : pcfg[i][`BIT_OUT_EN];
      end else begin : g_plain
        assign oe_eff[i] = pcfg[i][`BIT_OUT_EN];
      end

      if (i >= `PIN_SERIAL_FIRST && i <= `PIN_SERIAL_LAST) begin : g_sdat
        assign dat_eff[i] = claim[i - `PIN_SERIAL_FIRST] ?
          SER_DO[i - `PIN_SERIAL_FIRST] : data_all[i];
      end else if (i == `PIN_P12) begin : g_clk
        assign dat_eff[i] = pcfg[i][`BIT_CLK_OUT] ?
          sel_clk_reg : data_all[i];
      end else begin : g_dat
        assign dat_eff[i] = data_all[i];
      end

      if (i == `PIN_P10) begin : g_odonly
        // This pad has no high-side driver at all
        assign od_eff[i] = 1'b1;
      end else begin : g_od
        assign od_eff[i] = pcfg[i][`BIT_OPEN_DRAIN];
      end

      // Open drain releases the pad for a one, sinks for a zero
      assign drive_next[i] = oe_eff[i] & ~(od_eff[i] & dat_eff[i]);
      assign out_next[i] = od_eff[i] ? 1'b0 : dat_eff[i];

      // Active-low selects the falling edge
      assign edge_hit[i] = primed_reg & (pcfg[i][`BIT_ACT_LOW] ?
        (pin_prev_reg[i] & ~PIN_IN[i]) :
        (~pin_prev_reg[i] & PIN_IN[i]));
    end
  endgenerate

  // Registered pad controls, all outputs come straight from flops
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PIN_OE <= `RST_PINS;
      PIN_OUT <= `RST_PINS;
      PIN_PULLUP <= `RST_PINS;
      PIN_TTL <= `RST_PINS;
      PIN_HISINK <= `RST_PINS;
    end else begin
      PIN_OE <= drive_next;
      PIN_OUT <= out_next;
      for (int k = 0; k < 16; k++) begin
        PIN_PULLUP[k] <= pcfg[k][`BIT_PULLUP];
        PIN_TTL[k] <= pcfg[k][`BIT_TTL];
        PIN_HISINK[k] <= pcfg[k][`BIT_HIGH_SINK];
      end
    end
  end

  // Input history; priming skips a false edge right after reset
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_prev_reg <= `RST_PINS;
      primed_reg <= 1'b0;
      sel_clk_reg <= 1'b0;
    end else begin
      pin_prev_reg <= PIN_IN;
      primed_reg <= 1'b1;
      sel_clk_reg <= SEL_CLK;
    end
  end

  // Interrupt pulses; the external pair is gated by the controller
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      EXT_IRQ_A <= 1'b0;
      EXT_IRQ_B <= 1'b0;
      GPIO_IRQ <= `RST_PINS;
    end else begin
      EXT_IRQ_A <= edge_hit[`PIN_EXT_IRQ_A];
      EXT_IRQ_B <= edge_hit[`PIN_EXT_IRQ_B];
      for (int k = 0; k < 16; k++) begin
        GPIO_IRQ[k] <= edge_hit[k] & pcfg[k][`BIT_IRQ_EN];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_od_float;
    @(posedge SYS_CLK) disable iff (!RSTN)
    (cfg07_reg[2] && cfg07_reg[0] && p0_data_reg[7]) |=> !PIN_OE[7];
  endproperty
  a_od_float: assert property (p_od_float)
    else $error("open-drain pin drove with data one");

  property p_push_pull;
    @(posedge SYS_CLK) disable iff (!RSTN)
    (!cfg07_reg[2] && cfg07_reg[0]) |=>
      (PIN_OE[7] && PIN_OUT[7] == $past(p0_data_reg[7]));
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("push-pull pin not driving its data");

  property p_pullup;
    @(posedge SYS_CLK) disable iff (!RSTN)
    1'b1 |=> PIN_PULLUP[7] == $past(cfg07_reg[1]);
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up does not follow its bit");

  property p_oe_off;
    @(posedge SYS_CLK) disable iff (!RSTN)
    !cfg01_reg[0] |=> !PIN_OE[1];
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("driver on with output enable clear");

  property p_crystal;
    @(posedge SYS_CLK) disable iff (!RSTN)
    crystal_osc_on |=> (!PIN_OE[0] && !PIN_OE[1]);
  endproperty
  a_crystal: assert property (p_crystal)
    else $error("crystal pin driven while oscillator on");

  property p_serial;
    @(posedge SYS_CLK) disable iff (!RSTN)
    (claim[0] && !pcfg[11][2]) |=> PIN_OE[11] == $past(SER_OE[0]);
  endproperty
  a_serial: assert property (p_serial)
    else $error("claimed serial pin ignores serial enable");

  sequence s_rise_a;
    !PIN_IN[3] ##1 (PIN_IN[3] && !cfg03_reg[5]);
  endsequence
  sequence s_fall_a;
    PIN_IN[3] ##1 (!PIN_IN[3] && cfg03_reg[5]);
  endsequence
  property p_ext_edge;
    @(posedge SYS_CLK) disable iff (!RSTN)
    (primed_reg ##0 (s_rise_a or s_fall_a)) |=> EXT_IRQ_A;
  endproperty
  a_ext_edge: assert property (p_ext_edge)
    else $error("external interrupt edge missed");

  property p_od_only;
    @(posedge SYS_CLK) disable iff (!RSTN)
    PIN_OE[8] |-> !PIN_OUT[8];
  endproperty
  a_od_only: assert property (p_od_only)
    else $error("open-drain-only pin driven high");

  property p_shared_pu;
    @(posedge SYS_CLK) disable iff (!RSTN)
    1'b1 |=> (PIN_PULLUP[8] == $past(cfg10_reg[1]) &&
              PIN_PULLUP[9] == $past(cfg10_reg[1]));
  endproperty
  a_shared_pu: assert property (p_shared_pu)
    else $error("shared pull-ups disagree with control bit");

  property p_clk_out;
    @(posedge SYS_CLK) disable iff (!RSTN)
    (cfg12_reg[7] && !cfg12_reg[2]) |=> PIN_OUT[10] == $past(sel_clk_reg);
  endproperty
  a_clk_out: assert property (p_clk_out)
    else $error("selected clock not on pin");

  property p_irq_block;
    @(posedge SYS_CLK) disable iff (!RSTN)
    !cfg07_reg[6] |=> !GPIO_IRQ[7];
  endproperty
  a_irq_block: assert property (p_irq_block)
    else $error("disabled pin raised an interrupt");

  property p_ttl;
    @(posedge SYS_CLK) disable iff (!RSTN)
    1'b1 |=> PIN_TTL[1] == $past(cfg01_reg[4]);
  endproperty
  a_ttl: assert property (p_ttl)
    else $error("threshold select does not follow its bit");

  property p_read_pins;
    @(posedge SYS_CLK) disable iff (!RSTN)
    (RD_EN && ADDR == `OFS_PORT0_DATA) |=> RD_DATA == $past(PIN_IN[7:0]);
  endproperty
  a_read_pins: assert property (p_read_pins)
    else $error("port read does not return pin levels");

  property p_cfg_readback;
    @(posedge SYS_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `OFS_PORT0_PIN7_CONFIG) ##1
      (RD_EN && ADDR == `OFS_PORT0_PIN7_CONFIG) |=>
      RD_DATA == ($past(WR_DATA, 2) & `MASK_PORT0_PIN7);
  endproperty
  a_cfg_readback: assert property (p_cfg_readback)
    else $error("pin 7 config readback wrong");

endmodule

/* dv/pad_board_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Board circuitry on the pads
// ----------------------------------------------------------------
module pad_board_model (
  input wire logic clk,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] pin_pullup,
  input wire logic [15:0] drv_en,
  input wire logic [15:0] drv_val,
  output logic [15:0] pin_in
);
  logic [15:0] float_reg = 16'h5555;

  // Floating pads wander, so a missing drive never reads as a stale level
  always_ff @(posedge clk) begin
    float_reg <= ~float_reg;
  end

  // Pad level: chip driver first, then board driver, then pull-up
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (drv_en[i]) begin
        pin_in[i] = drv_val[i];
      end else if (pin_pullup[i]) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = float_reg[i];
      end
    end
  end
endmodule

/* dv/gpio_pin_configuration_tb.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench for the pin configuration block
// ----------------------------------------------------------------
module gpio_pin_configuration_tb;
  logic SYS_CLK = 1'b0;
  logic RSTN;
  gpio_cfg_pkg::byte_t ADDR, WR_DATA, RD_DATA;
  logic WR_EN, RD_EN, SEL_CLK, EXT_IRQ_A, EXT_IRQ_B;
  gpio_cfg_pkg::pin_vec_t PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP;
  gpio_cfg_pkg::pin_vec_t PIN_TTL, PIN_HISINK, GPIO_IRQ;
  gpio_cfg_pkg::serial_vec_t SER_OE, SER_DO;
  gpio_cfg_pkg::pin_vec_t drv_en, drv_val;
  gpio_cfg_pkg::pin_vec_t cnt_a = 16'h0000, cnt_b = 16'h0000;
  gpio_cfg_pkg::pin_vec_t cnt_7 = 16'h0000, ba, bb;
  gpio_cfg_pkg::byte_t v;
  gpio_cfg_pkg::byte_t regs[7] = '{8'h06, 8'h08, 8'h09, 8'h0C, 8'h0D,
                                   8'h0E, 8'h0F};
  gpio_cfg_pkg::byte_t wmask[7] = '{8'hFF, 8'h37, 8'h37, 8'h77, 8'hE3,
                                    8'h65, 8'hF7};
  int failures = 0;
  int checks_done = 0;

  always #5 SYS_CLK = ~SYS_CLK;

  gpio_pin_configuration uut (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .PIN_IN(PIN_IN),
    .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_PULLUP(PIN_PULLUP),
    .PIN_TTL(PIN_TTL), .PIN_HISINK(PIN_HISINK), .SER_OE(SER_OE),
    .SER_DO(SER_DO), .SEL_CLK(SEL_CLK), .EXT_IRQ_A(EXT_IRQ_A),
    .EXT_IRQ_B(EXT_IRQ_B), .GPIO_IRQ(GPIO_IRQ)
  );

  pad_board_model board (
    .clk(SYS_CLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE),
    .pin_pullup(PIN_PULLUP), .drv_en(drv_en), .drv_val(drv_val),
    .pin_in(PIN_IN)
  );

  // Pulse counters; a doubled pulse shows up as a count of two
  always @(posedge SYS_CLK) begin
    if (EXT_IRQ_A === 1'b1) cnt_a <= cnt_a + 16'h0001;
    if (EXT_IRQ_B === 1'b1) cnt_b <= cnt_b + 16'h0001;
    if (GPIO_IRQ[7] === 1'b1) cnt_7 <= cnt_7 + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input gpio_cfg_pkg::pin_vec_t got,
                     input gpio_cfg_pkg::pin_vec_t exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input gpio_cfg_pkg::byte_t a,
                    input gpio_cfg_pkg::byte_t d);
    @(posedge SYS_CLK);
    WR_EN <= 1'b1;
    ADDR <= a;
    WR_DATA <= d;
    @(posedge SYS_CLK);
    WR_EN <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input gpio_cfg_pkg::byte_t a,
                    output gpio_cfg_pkg::byte_t d);
    @(posedge SYS_CLK);
    RD_EN <= 1'b1;
    ADDR <= a;
    @(posedge SYS_CLK);
    RD_EN <= 1'b0;
    #1;
    d = RD_DATA;
  endtask

  // Write then read back with no idle cycle between the strobes
  task automatic wr_rd(input gpio_cfg_pkg::byte_t a,
                       input gpio_cfg_pkg::byte_t d,
                       output gpio_cfg_pkg::byte_t q);
    @(posedge SYS_CLK);
    WR_EN <= 1'b1;
    ADDR <= a;
    WR_DATA <= d;
    @(posedge SYS_CLK);
    WR_EN <= 1'b0;
    RD_EN <= 1'b1;
    @(posedge SYS_CLK);
    RD_EN <= 1'b0;
    #1;
    q = RD_DATA;
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask

  task give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard, far beyond the real run length
  initial begin
    #200000;
    failures++;
    give_verdict;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    RSTN = 1'b0;
    WR_EN = 1'b0;
    RD_EN = 1'b0;
    ADDR = 8'h00;
    WR_DATA = 8'h00;
    SER_OE = 4'h0;
    SER_DO = 4'h0;
    SEL_CLK = 1'b0;
    drv_en = 16'h0098;
    drv_val = 16'h0000;
    repeat (5) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    #1;
    chk(PIN_OE, 16'h0000);
    // Reset values, writable bits, then back to zero
    for (int i = 0; i < 7; i++) begin
      rd(regs[i], v);
      chk(v, 8'h00);
      wr_rd(regs[i], 8'hFF, v);
      chk(v, wmask[i]);
      wr(regs[i], 8'h00);
    end
    rd(8'h07, v);
    chk(v, 8'h00);
    // Push-pull then open drain on port 0 pin 1
    wr(8'h00, 8'h02);
    wr(8'h06, 8'h01);
    pause(2);
    chk({PIN_OE[1], PIN_OUT[1]}, 2'b11);
    wr(8'h00, 8'h00);
    pause(2);
    chk({PIN_OE[1], PIN_OUT[1]}, 2'b10);
    wr(8'h06, 8'h05);
    pause(2);
    chk({PIN_OE[1], PIN_OUT[1]}, 2'b10);
    wr(8'h00, 8'h02);
    pause(2);
    chk(PIN_OE[1], 1'b0);
    wr(8'h06, 8'h1A);
    pause(2);
    chk({PIN_PULLUP[1], PIN_TTL[1], PIN_HISINK[1]}, 3'b111);
    wr(8'h06, 8'h00);
    pause(2);
    chk({PIN_PULLUP[1], PIN_TTL[1], PIN_HISINK[1]}, 3'b000);
    // Crystal running keeps both crystal pads undriven
    wr(8'h06, 8'h01);
    wr(8'h1B, 8'h03);
    pause(2);
    chk(PIN_OE[1:0], 2'b00);
    wr(8'h1B, 8'h01);
    pause(2);
    chk(PIN_OE[1:0], 2'b11);
    wr(8'h1B, 8'h00);
    wr(8'h06, 8'h00);
    // Serial claim owns the enables of pins 11..14
    SER_OE <= 4'hA;
    SER_DO <= 4'hA;
    wr(8'h01, 8'h78);
    wr(8'h1A, 8'hFF);
    pause(2);
    chk(PIN_OE[14:11], 4'hA);
    wr(8'h1A, 8'hF0);
    pause(2);
    chk({PIN_OE[14:11], PIN_OUT[14:11]}, 8'hFF);
    wr(8'h1A, 8'h00);
    // Port 1 pin 0 only sinks; shared pull-up on pins 8 and 9
    wr(8'h01, 8'h01);
    wr(8'h0D, 8'h01);
    pause(2);
    chk(PIN_OE[8], 1'b0);
    wr(8'h01, 8'h00);
    pause(2);
    chk({PIN_OE[8], PIN_OUT[8]}, 2'b10);
    wr(8'h0D, 8'h02);
    pause(2);
    chk({PIN_PULLUP[9:8], PIN_OE[8]}, 3'b110);
    wr(8'h0D, 8'h00);
    pause(2);
    chk(PIN_PULLUP[9:8], 2'b00);
    // External edge interrupts, both pins, both polarities
    for (int k = 0; k < 2; k++) begin
      for (int p = 0; p < 2; p++) begin
        wr(8'(8 + k), p ? 8'h20 : 8'h00);
        pause(3);
        ba = cnt_a;
        bb = cnt_b;
        drv_val[3 + k] <= 1'b1;
        pause(4);
        chk(k ? cnt_b - bb : cnt_a - ba, p ? 16'h0000 : 16'h0001);
        drv_val[3 + k] <= 1'b0;
        pause(4);
        chk(k ? cnt_b - bb : cnt_a - ba, 16'h0001);
        chk(k ? cnt_a - ba : cnt_b - bb, 16'h0000);
      end
      wr(8'(8 + k), 8'h00);
    end
    // Software-made edge through the pin's own driver
    drv_en[3] <= 1'b0;
    wr(8'h08, 8'h01);
    pause(4);
    ba = cnt_a;
    wr(8'h00, 8'h08);
    pause(4);
    chk(cnt_a - ba, 16'h0001);
    wr(8'h08, 8'h07);
    pause(2);
    chk({PIN_OE[3], PIN_PULLUP[3]}, 2'b01);
    drv_en[3] <= 1'b1;
    wr(8'h08, 8'h00);
    // Pin interrupt follows its enable bit
    wr(8'h0C, 8'h40);
    pause(2);
    ba = cnt_7;
    drv_val[7] <= 1'b1;
    pause(4);
    chk(cnt_7 - ba, 16'h0001);
    // Falling polarity, so only the cleared enable can keep this quiet
    wr(8'h0C, 8'h20);
    pause(2);
    ba = cnt_7;
    drv_val[7] <= 1'b0;
    pause(4);
    chk(cnt_7 - ba, 16'h0000);
    // Pin 7 push-pull then open drain; chip drive wins over the board
    wr(8'h0C, 8'h01);
    wr(8'h00, 8'h80);
    pause(2);
    chk({PIN_OE[7], PIN_OUT[7]}, 2'b11);
    wr(8'h0C, 8'h05);
    pause(2);
    chk(PIN_OE[7], 1'b0);
    wr(8'h0C, 8'h00);
    // Clock output replaces the data bit on port 1 pin 2
    wr(8'h01, 8'h00);
    wr(8'h0F, 8'h81);
    SEL_CLK <= 1'b1;
    pause(4);
    chk({PIN_OE[10], PIN_OUT[10]}, 2'b11);
    SEL_CLK <= 1'b0;
    pause(4);
    chk(PIN_OUT[10], 1'b0);
    SEL_CLK <= 1'b1;
    wr(8'h0F, 8'h01);
    pause(4);
    chk(PIN_OUT[10], 1'b0);
    // Port read returns the pad levels
    drv_val[4] <= 1'b1;
    pause(3);
    rd(8'h00, v);
    chk(v & 8'h98, 8'h10);
    wr(8'h0D, 8'h00);
    give_verdict;
  end
endmodule
